/* File: shared/kfx_pkg.sv */
// Package: constants and types for the key stream field XOR block
// Notes on behaviour
// R1: Each D-field pair takes two key segments of exactly segment_length.
// R2: segment_length is header plus payload; header 40, 80 (4a), 120 (4b).
// R3: Payload 800/320/80/640/672 by slot, times 1, 2, 3, 4 or 6 by config.
// R4: Segment bits are used in generator order, index 0 to length minus one.
// R5: Configs 1a-3, 5, 6, control tail: bits 0..39 XOR tail a8..a47.
// R6: Configs 1a-3, 5, 6, other tail: bits 0..39 are discarded.
// R7: Configs 1a-3, 5, 6, unprotected B: bit i XOR segment bit i+40.
// R8: Config 4a, control tail: bits 0..79 XOR tail a8..a87.
// R9: Config 4a, other tail: bits 0..79 are discarded.
// R10: Config 4a, unprotected B: bit i XOR segment bit i+80.
// R11: Config 4b, control tail: bits 0..119 XOR tail a8..a127.
// R12: Config 4b, other tail: bits 0..119 are discarded.
// R13: Config 4b, unprotected B: bit i XOR segment bit i+120.
// R14: B bits to encrypt follow slot and config, equal to payload portion; the code instead takes the count from BCOUNT, at most the payload portion.
// R15: A B count above the payload portion is flagged and clamped.
// R16: Protected format: check bits and X-field pass unencrypted.
// R17: Same mapping decrypts; uncovered bits pass, leftover key bits drop.
package kfx_pkg;
    localparam int IDX_W = 13;
    typedef logic [IDX_W-1:0] kfx_idx_t;
    typedef enum logic [2:0] {
        CFG_1A = 3'h0, CFG_1B = 3'h1, CFG_2 = 3'h2, CFG_3 = 3'h3,
        CFG_4A = 3'h4, CFG_4B = 3'h5, CFG_5 = 3'h6, CFG_6 = 3'h7
    } kfx_cfg_t;
    typedef enum logic [2:0] {
        SLOT_DOUBLE = 3'h0, SLOT_FULL = 3'h1, SLOT_HALF = 3'h2,
        SLOT_L640 = 3'h3, SLOT_L672 = 3'h4
    } kfx_slot_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_HDR = 2'b01, ST_PAY = 2'b11, ST_DRAIN = 2'b10
    } kfx_state_t;
    localparam kfx_idx_t HDR_BASE   = 13'h0028;
    localparam kfx_idx_t HDR_4A     = 13'h0050;
    localparam kfx_idx_t HDR_4B     = 13'h0078;
    localparam kfx_idx_t PAY_DOUBLE = 13'h0320;
    localparam kfx_idx_t PAY_FULL   = 13'h0140;
    localparam kfx_idx_t PAY_HALF   = 13'h0050;
    localparam kfx_idx_t PAY_L640   = 13'h0280;
    localparam kfx_idx_t PAY_L672   = 13'h02A0;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_BCOUNT = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_SEGLEN = 8'h0C;
    localparam int CTRL_CFG_LSB   = 0;
    localparam int CTRL_SLOT_LSB  = 4;
    localparam int CTRL_TAIL_BIT  = 8;
    localparam int CTRL_PROT_BIT  = 9;
    localparam int CTRL_START_BIT = 31;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_ERR_BIT   = 1;
    localparam int STAT_HALF_BIT  = 2;
    localparam logic [9:0] CTRL_RST   = 10'h000;
    localparam kfx_idx_t   BCOUNT_RST = 13'h0320;
    typedef struct packed {
        kfx_cfg_t  cfg;
        kfx_slot_t slot;
        logic      tailCtl;
        logic      protFmt;
        kfx_idx_t  bitCount;
    } kfx_ctrl_t;
endpackage : kfx_pkg

/* File: logic/kfx_seg_len.sv */
// Segment length lookup from configuration and slot type
`timescale 1ns/100ps
module kfx_seg_len
    import kfx_pkg::*;
(
    input  kfx_cfg_t  cfg,
    input  kfx_slot_t slot,
    output kfx_idx_t  hdrLen,
    output kfx_idx_t  payLen,
    output kfx_idx_t  segLen
);
    kfx_idx_t   base;
    logic [2:0] mult;

    always_comb
    begin
        unique case (cfg)
            CFG_4A:  begin hdrLen = HDR_4A;   mult = 3'h2; end // [R2] [R3]
            CFG_4B:  begin hdrLen = HDR_4B;   mult = 3'h3; end // [R2] [R3]
            CFG_2:   begin hdrLen = HDR_BASE; mult = 3'h2; end // [R3]
            CFG_3:   begin hdrLen = HDR_BASE; mult = 3'h3; end // [R3]
            CFG_5:   begin hdrLen = HDR_BASE; mult = 3'h4; end // [R3]
            CFG_6:   begin hdrLen = HDR_BASE; mult = 3'h6; end // [R3]
            default: begin hdrLen = HDR_BASE; mult = 3'h1; end // [R2]
        endcase
    end

    always_comb
    begin
        unique case (slot)
            SLOT_DOUBLE: base = PAY_DOUBLE; // [R3]
            SLOT_FULL:   base = PAY_FULL;
            SLOT_HALF:   base = PAY_HALF;
            SLOT_L640:   base = PAY_L640;
            SLOT_L672:   base = PAY_L672;
            default:     base = PAY_FULL; // Unused codes read as full slot
        endcase
    end

    // Worst case 800 x 6 plus 40 still fits the index width
    assign payLen = kfx_idx_t'(base * kfx_idx_t'(mult)); // [R14]
    assign segLen = kfx_idx_t'(hdrLen + payLen); // [R2]
endmodule : kfx_seg_len

/* File: logic/kfx_apb_regs.sv */
// APB register file for the key stream field XOR block
`timescale 1ns/100ps
module kfx_apb_regs
    import kfx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output kfx_ctrl_t        ctrl,
    output logic             startPulse,
    input  wire logic        busy,
    input  wire logic        errSet,
    input  wire logic        segHalf,
    input  kfx_idx_t         segLen
);
    logic [9:0]  ctrl_reg, ctrl_next;
    kfx_idx_t    bcnt_reg, bcnt_next;
    logic        err_reg, err_next;
    logic        start_reg, start_next;
    logic        rdy_reg, rdy_next;
    logic        slv_reg, slv_next;
    logic [31:0] rd_reg, rd_next;
    logic        wr;
    logic        hit;
    logic [31:0] rdVal;

    assign wr = psel && penable && rdy_reg && pwrite;

    always_comb
    begin
        hit   = 1'b1;
        rdVal = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL:   rdVal[9:0] = ctrl_reg;
            OFS_BCOUNT: rdVal[IDX_W-1:0] = bcnt_reg;
            OFS_STATUS:
            begin
                rdVal[STAT_BUSY_BIT] = busy;
                rdVal[STAT_ERR_BIT]  = err_reg;
                rdVal[STAT_HALF_BIT] = segHalf;
            end
            OFS_SEGLEN: rdVal[IDX_W-1:0] = segLen;
            default:    hit = 1'b0;
        endcase
    end

    always_comb
    begin
        ctrl_next  = ctrl_reg;
        bcnt_next  = bcnt_reg;
        start_next = 1'b0;
        rdy_next   = psel && penable && !rdy_reg; // One wait state
        slv_next   = psel && penable && !rdy_reg && !hit;
        rd_next    = (psel && penable && !rdy_reg && !pwrite) ? rdVal : rd_reg;
        err_next   = err_reg;
        if (wr && hit && paddr == OFS_CTRL)
        begin
            ctrl_next  = pwdata[9:0];
            start_next = pwdata[CTRL_START_BIT];
        end
        if (wr && hit && paddr == OFS_BCOUNT)
            bcnt_next = pwdata[IDX_W-1:0];
        if (wr && hit && paddr == OFS_STATUS && pwdata[STAT_ERR_BIT])
            err_next = 1'b0;
        if (errSet)
            err_next = 1'b1; // Set wins over clear [R15]
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg  <= CTRL_RST;
            bcnt_reg  <= BCOUNT_RST;
            err_reg   <= 1'b0;
            start_reg <= 1'b0;
            rdy_reg   <= 1'b0;
            slv_reg   <= 1'b0;
            rd_reg    <= 32'h0000_0000;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            bcnt_reg  <= bcnt_next;
            err_reg   <= err_next;
            start_reg <= start_next;
            rdy_reg   <= rdy_next;
            slv_reg   <= slv_next;
            rd_reg    <= rd_next;
        end
    end

    assign prdata        = rd_reg;
    assign pready        = rdy_reg;
    assign pslverr       = slv_reg;
    assign startPulse    = start_reg;
    assign ctrl.cfg      = kfx_cfg_t'(ctrl_reg[CTRL_CFG_LSB +: 3]);
    assign ctrl.slot     = kfx_slot_t'(ctrl_reg[CTRL_SLOT_LSB +: 3]);
    assign ctrl.tailCtl  = ctrl_reg[CTRL_TAIL_BIT];
    assign ctrl.protFmt  = ctrl_reg[CTRL_PROT_BIT];
    assign ctrl.bitCount = bcnt_reg;
endmodule : kfx_apb_regs

/* File: logic/kfx_keystream_xor.sv */
// Top: applies key stream segments to the A tail and the B field
`timescale 1ns/100ps
module kfx_keystream_xor
    import kfx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ksValid,
    input  wire logic        ksBit,
    output logic             ksReady,
    input  wire logic        dValid,
    input  wire logic        dBit,
    input  wire logic        dSkip,
    output logic             dReady,
    output logic             outValid,
    output logic             outBit,
    output logic             outKind
);
    kfx_ctrl_t  ctrl;
    logic       startPulse;
    logic       errSet;
    kfx_idx_t   hdrLen;
    kfx_idx_t   payLen;
    kfx_idx_t   segLen;

    kfx_state_t st_reg, st_next;
    kfx_idx_t   idx_reg, idx_next;
    kfx_idx_t   dcnt_reg, dcnt_next;
    kfx_idx_t   hdr_reg, hdr_next;
    kfx_idx_t   seg_reg, seg_next;
    kfx_idx_t   bcnt_reg, bcnt_next;
    logic       tail_reg, tail_next;
    logic       prot_reg, prot_next;
    logic       half_reg, half_next;
    logic       ksr_reg, ksr_next;
    logic       dr_reg, dr_next;
    logic       ov_reg, ov_next;
    logic       ob_reg, ob_next;
    logic       ok_reg, ok_next;

    logic       skipNow;
    logic       needKey;
    logic       needData;
    logic       take;

    kfx_apb_regs u_regs (
        .clk        (clk),
        .rstn       (rstn),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .ctrl       (ctrl),
        .startPulse (startPulse),
        .busy       (st_reg != ST_IDLE),
        .errSet     (errSet),
        .segHalf    (half_reg),
        .segLen     (segLen)
    );

    kfx_seg_len u_len (
        .cfg    (ctrl.cfg),
        .slot   (ctrl.slot),
        .hdrLen (hdrLen),
        .payLen (payLen),
        .segLen (segLen)
    );

    // Skip marks only count in the protected format
    assign skipNow = prot_reg && dSkip; // [R16]

    always_comb
    begin
        needKey  = 1'b0;
        needData = 1'b0;
        unique case (st_reg)
            ST_IDLE:  ;
            ST_HDR:
            begin
                needKey  = 1'b1;
                needData = tail_reg;
            end
            ST_PAY:
            begin
                needKey  = !skipNow;
                needData = 1'b1;
            end
            ST_DRAIN: needKey = 1'b1;
        endcase
    end

    // When both are needed, key and data move together, so a lone valid waits for its partner
    assign take = (st_reg != ST_IDLE)
               && (!needKey  || (ksValid && ksr_reg))
               && (!needData || (dValid && dr_reg));

    always_comb
    begin
        st_next   = st_reg;
        idx_next  = idx_reg;
        dcnt_next = dcnt_reg;
        hdr_next  = hdr_reg;
        seg_next  = seg_reg;
        bcnt_next = bcnt_reg;
        tail_next = tail_reg;
        prot_next = prot_reg;
        half_next = half_reg;
        ov_next   = 1'b0;
        ob_next   = ob_reg;
        ok_next   = ok_reg;
        errSet    = 1'b0;
        unique case (st_reg)
            ST_IDLE:
            begin
                if (startPulse)
                begin
                    hdr_next  = hdrLen; // [R2]
                    seg_next  = segLen; // [R1]
                    tail_next = ctrl.tailCtl;
                    prot_next = ctrl.protFmt;
                    idx_next  = '0;
                    dcnt_next = '0;
                    st_next   = ST_HDR;
                    bcnt_next = ctrl.bitCount; // [R14]
                    if (ctrl.bitCount > payLen)
                    begin
                        // Never read past the segment end
                        bcnt_next = payLen; // [R15]
                        errSet    = 1'b1; // [R15]
                    end
                end
            end
            ST_HDR:
            begin
                if (take)
                begin
                    idx_next = idx_reg + 13'h0001; // [R4]
                    if (tail_reg)
                    begin
                        ov_next = 1'b1; // [R5] [R8] [R11]
                        ob_next = dBit ^ ksBit; // [R5] [R8] [R11]
                        ok_next = 1'b0;
                    end
                    // Otherwise the key bit is dropped [R6] [R9] [R12]
                    if (idx_reg == hdr_reg - 13'h0001)
                        st_next = (bcnt_reg == '0) ? ST_DRAIN : ST_PAY;
                end
            end
            ST_PAY:
            begin
                if (take)
                begin
                    ov_next = 1'b1;
                    ok_next = 1'b1;
                    if (skipNow)
                        ob_next = dBit; // [R16]
                    else
                    begin
                        // Key index is header length plus i [R7] [R10] [R13]
                        ob_next   = dBit ^ ksBit; // [R7] [R10] [R13] [R17]
                        idx_next  = idx_reg + 13'h0001; // [R4]
                        dcnt_next = dcnt_reg + 13'h0001;
                        if (dcnt_reg + 13'h0001 == bcnt_reg)
                        begin
                            if (idx_reg + 13'h0001 == seg_reg)
                            begin
                                st_next   = ST_IDLE;
                                half_next = !half_reg; // [R1]
                            end
                            else
                                st_next = ST_DRAIN;
                        end
                    end
                end
            end
            ST_DRAIN:
            begin
                if (take)
                begin
                    // Leftover key bits are consumed and dropped [R17]
                    idx_next = idx_reg + 13'h0001; // [R4]
                    if (idx_reg + 13'h0001 == seg_reg)
                    begin
                        st_next   = ST_IDLE; // [R1]
                        half_next = !half_reg; // [R1]
                    end
                end
            end
        endcase
        ksr_next = (st_next != ST_IDLE); // [R1]
        dr_next  = (st_next == ST_PAY) || (st_next == ST_HDR && tail_next);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg   <= ST_IDLE;
            idx_reg  <= '0;
            dcnt_reg <= '0;
            hdr_reg  <= HDR_BASE;
            seg_reg  <= '0;
            bcnt_reg <= '0;
            tail_reg <= 1'b0;
            prot_reg <= 1'b0;
            half_reg <= 1'b0;
            ksr_reg  <= 1'b0;
            dr_reg   <= 1'b0;
            ov_reg   <= 1'b0;
            ob_reg   <= 1'b0;
            ok_reg   <= 1'b0;
        end
        else
        begin
            st_reg   <= st_next;
            idx_reg  <= idx_next;
            dcnt_reg <= dcnt_next;
            hdr_reg  <= hdr_next;
            seg_reg  <= seg_next;
            bcnt_reg <= bcnt_next;
            tail_reg <= tail_next;
            prot_reg <= prot_next;
            half_reg <= half_next;
            ksr_reg  <= ksr_next;
            dr_reg   <= dr_next;
            ov_reg   <= ov_next;
            ob_reg   <= ob_next;
            ok_reg   <= ok_next;
        end
    end

    assign ksReady  = ksr_reg;
    assign dReady   = dr_reg;
    assign outValid = ov_reg;
    assign outBit   = ob_reg;
    assign outKind  = ok_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_hdr_xor: assert property ( // [R5]
        (st_reg == ST_HDR && tail_reg && take)
        |=> (outValid && !outKind && outBit == $past(dBit ^ ksBit)))
        else $error("tail bit not keyed");

    chk_hdr_drop: assert property ( // [R6]
        (st_reg == ST_HDR && !tail_reg) |=> !outValid)
        else $error("discarded header bit reached output");

    chk_hdr_len: assert property ( // [R2]
        (st_reg == ST_HDR && take && idx_reg != hdr_reg - 13'h0001)
        |=> st_reg == ST_HDR)
        else $error("header phase left early");

    chk_pay_xor: assert property ( // [R7]
        (st_reg == ST_PAY && take && !skipNow)
        |=> (outKind && outBit == $past(dBit ^ ksBit)
             && idx_reg == $past(idx_reg) + 13'h0001))
        else $error("payload bit not keyed in order");

    chk_skip_pass: assert property ( // [R16]
        (st_reg == ST_PAY && take && skipNow)
        |=> (outBit == $past(dBit) && $stable(idx_reg)))
        else $error("protected bit was keyed");

    chk_seg_end: assert property ( // [R1]
        (st_reg != ST_IDLE) ##1 (st_reg == ST_IDLE)
        |-> (idx_reg == seg_reg && half_reg != $past(half_reg)))
        else $error("segment ended at wrong length");

    chk_count_clamp: assert property ( // [R15]
        (st_reg != ST_IDLE) |-> (bcnt_reg + hdr_reg <= seg_reg))
        else $error("B count runs past segment");

    chk_idx_bound: assert property ( // [R4]
        (st_reg != ST_IDLE) |-> (idx_reg < seg_reg))
        else $error("key index beyond segment");

    chk_idle_quiet: assert property ( // [R17]
        (st_reg == ST_IDLE) |-> (!ksReady && !dReady))
        else $error("stream ready while idle");

    chk_drain_quiet: assert property ( // [R17]
        (st_reg == ST_DRAIN) |-> (!dReady && ksReady))
        else $error("field stream open while draining");

    chk_tail_drop: assert property ( // [R9]
        (st_reg == ST_HDR && !tail_reg && take)
        |=> (idx_reg == $past(idx_reg) + 13'h0001 && !outValid))
        else $error("dropped header key not consumed");

    chk_clamp_load: assert property ( // [R15]
        (st_reg == ST_IDLE && startPulse && ctrl.bitCount > payLen)
        |=> (st_reg == ST_HDR && bcnt_reg == $past(payLen)))
        else $error("oversized B count not clamped");
endmodule : kfx_keystream_xor

/* File: sim/kfx_far_model.sv */
// Far side model: key stream generator and MAC bit source with stalls
`timescale 1ns/100ps
module kfx_far_model
    import kfx_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ksReady,
    input  wire logic dReady,
    input  wire logic kStall,
    input  wire logic dStall,
    input  wire logic dNew,
    input  wire logic skipNew,
    output logic      ksValid,
    output logic      ksBit,
    output logic      dValid,
    output logic      dBit,
    output logic      dSkip
);
    kfx_idx_t kIdx_reg;
    kfx_idx_t kIdx_next;
    logic     keyTake;
    logic     dTake;

    function automatic logic keyFn(input kfx_idx_t k);
        return (^(k & 13'h01A5)) ^ k[1];
    endfunction : keyFn

    // Mirrors the block's take rule so a held bit is never lost
    always_comb
    begin
        keyTake   = ksReady & ksValid & (~dReady | (dValid & ~dSkip));
        dTake     = dReady & dValid & (dSkip | ksValid);
        kIdx_next = keyTake ? kIdx_reg + 13'h0001 : kIdx_reg;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            kIdx_reg <= '0;
            ksValid  <= 1'b0;
            ksBit    <= 1'b0;
            dValid   <= 1'b0;
            dBit     <= 1'b0;
            dSkip    <= 1'b0;
        end
        else
        begin
            kIdx_reg <= ksReady ? kIdx_next : '0;
            if (!ksReady)
                ksValid <= 1'b0;
            else if (!ksValid || keyTake)
            begin
                ksValid <= ~kStall;
                // Idle key line shows the inverse so no stale bit matches
                ksBit   <= kStall ? ~ksBit : keyFn(kIdx_next);
            end
            if (!dReady)
                dValid <= 1'b0;
            else if (!dValid || dTake)
            begin
                dValid <= ~dStall;
                dBit   <= dNew;
                dSkip  <= skipNew;
            end
        end
    end
endmodule : kfx_far_model

/* File: sim/kfx_keystream_xor_bench.sv */
// Bench: register, length table and stream checks of the XOR block
`timescale 1ns/100ps
module kfx_keystream_xor_bench
    import kfx_pkg::*;
();
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ksValid;
    logic        ksBit;
    logic        ksReady;
    logic        dValid;
    logic        dBit;
    logic        dSkip;
    logic        dReady;
    logic        outValid;
    logic        outBit;
    logic        outKind;
    logic        kStall = 1'b0;
    logic        dStall = 1'b0;
    logic        dNew = 1'b0;
    logic        skipNew = 1'b0;
    logic        slow = 1'b0;
    logic        skipOn = 1'b0;
    logic        tailG = 1'b0;
    logic        halfExp = 1'b0;
    logic [31:0] rnd;
    logic [1:0]  q[$];
    logic [1:0]  qe;
    kfx_idx_t    hdrG = '0;
    int          seed = 32'h9A449090;
    int          tIdx, kCnt, bCnt, keyCnt;
    int          n_fail = 0;
    int          compares = 0;

    always #20 clk = ~clk;

    kfx_keystream_xor DUT (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ksValid(ksValid), .ksBit(ksBit),
        .ksReady(ksReady), .dValid(dValid), .dBit(dBit), .dSkip(dSkip),
        .dReady(dReady), .outValid(outValid), .outBit(outBit),
        .outKind(outKind));

    kfx_far_model far (.clk(clk), .rstn(rstn), .ksReady(ksReady),
        .dReady(dReady), .kStall(kStall), .dStall(dStall), .dNew(dNew),
        .skipNew(skipNew), .ksValid(ksValid), .ksBit(ksBit),
        .dValid(dValid), .dBit(dBit), .dSkip(dSkip));

    function automatic logic keyFn(input kfx_idx_t k);
        return (^(k & 13'h01A5)) ^ k[1];
    endfunction : keyFn

    function automatic kfx_idx_t hdrOf(input logic [2:0] c);
        return c == 3'h4 ? 13'h0050 : c == 3'h5 ? 13'h0078 : 13'h0028;
    endfunction : hdrOf

    function automatic kfx_idx_t payOf(input logic [2:0] c, s);
        int b;
        int m;
        b = s == 0 ? 800 : s == 1 ? 320 : s == 2 ? 80 : s == 3 ? 640 : 672;
        m = c < 2 ? 1 : (c == 2 || c == 4) ? 2 : (c == 3 || c == 5) ? 3 :
            c == 6 ? 4 : 6;
        return kfx_idx_t'(b * m);
    endfunction : payOf

    task automatic cmp(input string nm, input logic [31:0] ex, got);
        compares++;
        if (got !== ex)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            cmp("pready", 1, 0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic finish_test;
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic seg(input logic [2:0] c, s, input logic t, p,
                       input kfx_idx_t bc);
        logic [31:0] r;
        logic        e;
        int          n;
        kfx_idx_t    pay;
        pay = payOf(c, s);
        apb(1'b1, OFS_BCOUNT, {19'h0, bc}, r, e);
        hdrG = hdrOf(c);
        tailG = t;
        skipOn = p;
        tIdx = 0;
        kCnt = 0;
        bCnt = 0;
        keyCnt = 0;
        apb(1'b1, OFS_CTRL, {1'b1, 21'h0, p, t, 1'b0, s, 1'b0, c}, r, e);
        n = 0;
        while (ksReady !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        while (ksReady === 1'b1 && n < 20000)
        begin
            @(posedge clk);
            n++;
        end
        repeat (3) @(posedge clk);
        cmp("keys", hdrG + pay, keyCnt);
        cmp("bbits", bc > pay ? pay : bc, bCnt);
        cmp("pending", 0, q.size());
        apb(1'b0, OFS_STATUS, 32'h0, r, e);
        halfExp = ~halfExp;
        cmp("err", bc > pay, r[STAT_ERR_BIT]);
        cmp("half", halfExp, r[STAT_HALF_BIT]);
        cmp("busy", 0, r[STAT_BUSY_BIT]);
        // Sticky error must be cleared or the next check is blind
        apb(1'b1, OFS_STATUS, 32'h2, r, e);
    endtask : seg

    always @(posedge clk)
    begin
        rnd = $random(seed);
        kStall <= rnd[0] & slow;
        dStall <= rnd[1] & slow;
        dNew <= rnd[2];
        skipNew <= skipOn & (rnd[4:3] == 2'b00);
    end

    always @(posedge clk)
    begin
        if (rstn === 1'b1)
        begin
            if (ksReady === 1'b1 && ksValid === 1'b1 &&
                (dReady !== 1'b1 || (dValid === 1'b1 && dSkip !== 1'b1)))
                keyCnt++;
            if (dReady === 1'b1 && dValid === 1'b1 &&
                (dSkip === 1'b1 || ksValid === 1'b1))
            begin
                if (tailG && tIdx < hdrG)
                begin
                    q.push_back({1'b0, dBit ^ keyFn(kfx_idx_t'(tIdx))});
                    tIdx++;
                end
                else
                begin
                    q.push_back({1'b1, dSkip ? dBit :
                        dBit ^ keyFn(hdrG + kfx_idx_t'(kCnt))});
                    kCnt += dSkip ? 0 : 1;
                    bCnt += dSkip ? 0 : 1;
                end
            end
            if (outValid === 1'b1)
            begin
                if (q.size() == 0)
                    cmp("extra", 0, 1);
                else
                begin
                    qe = q.pop_front();
                    cmp("kind", qe[1], outKind);
                    cmp("bit", qe[0], outBit);
                end
            end
        end
    end

    initial
    begin
        #(90000 * 40);
        n_fail++;
        finish_test();
    end

    initial
    begin
        logic [31:0] r;
        logic        e;
        logic [31:0] rr;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0, r, e);
        cmp("ctrl", 32'h0, r);
        apb(1'b0, OFS_BCOUNT, 32'h0, r, e);
        cmp("bcount", 32'h320, r);
        apb(1'b1, 8'h10, 32'hFFFF, r, e);
        cmp("wrerr", 1, e);
        apb(1'b0, 8'h10, 32'h0, r, e);
        cmp("rderr", 1, e);
        cmp("rdval", 0, r);
        for (int c = 0; c < 8; c++)
            for (int s = 0; s < 5; s++)
            begin
                apb(1'b1, OFS_CTRL, 32'(s << 4 | c), r, e);
                apb(1'b0, OFS_SEGLEN, 32'h0, r, e);
                cmp("seglen", hdrOf(c) + payOf(c, s), r);
            end
        seg(3'h0, 3'h2, 1'b1, 1'b0, 13'h0050);
        slow = 1'b1;
        seg(3'h4, 3'h2, 1'b1, 1'b0, 13'h00A0);
        seg(3'h5, 3'h2, 1'b0, 1'b0, 13'h00F0);
        seg(3'h7, 3'h2, 1'b0, 1'b0, 13'h0230);
        seg(3'h2, 3'h2, 1'b1, 1'b0, 13'h0064);
        seg(3'h1, 3'h4, 1'b1, 1'b0, 13'h02A0);
        for (int i = 0; i < 4; i++)
        begin
            rr = $random(seed);
            seg(rr[2:0], 3'h2, rr[3],
                1'b0, kfx_idx_t'(rr[12:4] % 500 + 1));
        end
        seg(3'h3, 3'h1, 1'b0, 1'b1, 13'h03C0);
        finish_test();
    end
endmodule : kfx_keystream_xor_bench
